// *** include/omc_pkg.sv ***
/*
 * Constants and types shared by the operating-mode control block:
 * register map, field positions, reset values, command and state codes.
 * Assumes a single 100 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package omc_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_PINFN = 8'h04;
    localparam logic [7:0] OFS_PULL_LO = 8'h08;
    localparam logic [7:0] OFS_PULL_HI = 8'h0C;
    localparam logic [7:0] OFS_SLEW_LO = 8'h10;
    localparam logic [7:0] OFS_SLEW_HI = 8'h14;

    // pin function register fields
    localparam int PINFN_DBG_OWN = 0;
    localparam int PINFN_XOUT = 1;
    localparam int PINFN_XIN = 2;
    localparam logic [2:0] PINFN_RESET = 3'h1;

    // status register fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_STRAP_LOW = 2;
    localparam int STAT_CPU_CLK = 3;

    // pads: eight ports of eight pins, port g holds the special pins
    localparam int PORT_CNT = 8;
    localparam int PAD_W = PORT_CNT * 8;
    localparam int PAD_DBG = 48;
    localparam int PAD_XOUT = 49;
    localparam int PAD_XIN = 50;
    localparam logic [PAD_W-1:0] PULL_RESET = 64'h0;
    localparam logic [PAD_W-1:0] SLEW_RESET = 64'h0;

    // reset vector location, high byte first
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

    // mode pin settles through the synchroniser before it is judged
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] INIT_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_RUN = 2'h1,
        ST_WAIT = 2'h3,
        ST_ENTER_DEBUG_INSTRUCTION = 2'h2
    } omc_state_t;

    typedef enum logic [2:0] {
        CMD_MEM = 3'h0,
        CMD_MEM_STAT = 3'h1,
        CMD_BDC_REG = 3'h2,
        CMD_HALT = 3'h3,
        CMD_CPU_REG = 3'h4,
        CMD_TRACE = 3'h5,
        CMD_GO = 3'h6
    } omc_cmd_t;

endpackage : omc_pkg

// *** src/omc_mode_ctrl.sv ***
/*
 * Operating-mode control: run, active background and pause (wait) modes,
 * debug command gating per mode, pad pull-up and slew overrides, and an
 * AHB-Lite register slave.
 * Assumes decoded debug commands and cpu events arrive on hclk, and the
 * mode pin arrives asynchronously.
 */
// Added by the designer: the register offsets and register access over AHB-Lite.
module omc_mode_ctrl import omc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // mode select pin, asynchronous
    input wire logic mode_select_debug_pin,
    // decoded debug commands from the single-wire debug logic
    input wire logic dbg_cmd_valid,
    input wire logic [2:0] dbg_cmd_code,
    output logic dbg_cmd_done,
    output logic dbg_cmd_rejected,
    output logic dbg_status_paused,
    // cpu events
    input wire logic enter_debug_instruction,
    input wire logic low_power_pause_instruction,
    input wire logic bdc_breakpoint,
    input wire logic dbg_breakpoint,
    input wire logic irq_request,
    // cpu control
    output logic cpu_clk_en,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    output logic ccr_imask_clear,
    output logic stacking_start,
    output logic trace_step,
    output logic [1:0] op_mode,
    // pad controls
    output logic [PAD_W-1:0] pad_pullup_en,
    output logic [PAD_W-1:0] pad_slew_en
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        omc_state_t st;
        logic [1:0] init_cnt;
        logic strap_low;
        logic [2:0] pinfn;
        logic [PAD_W-1:0] pull;
        logic [PAD_W-1:0] slew;
        logic [PAD_W-1:0] pad_pu;
        logic [PAD_W-1:0] pad_sr;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic vec_fetch;
        logic ccr_clr;
        logic stack_go;
        logic step;
        logic acc;
        logic rej;
        logic err;
    } omc_regs_t;

    localparam omc_regs_t REGS_RESET = '{
        st: ST_INIT,
        init_cnt: 2'h0,
        strap_low: 1'b0,
        pinfn: PINFN_RESET,
        pull: PULL_RESET,
        slew: SLEW_RESET,
        pad_pu: PULL_RESET,
        pad_sr: SLEW_RESET,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        rdata: 32'h0,
        vec_fetch: 1'b0,
        ccr_clr: 1'b0,
        stack_go: 1'b0,
        step: 1'b0,
        acc: 1'b0,
        rej: 1'b0,
        err: 1'b0
    };

    omc_regs_t s;
    omc_regs_t next_s;
    logic ms_level;
    logic bus_take;
    logic cmd_nonintr;
    omc_cmd_t cmd;
    logic cmd_halt;

    ////////////////////////////////////////////////////////////////////////

    omc_sync #(
        .RESET_VAL(1'b1)
    ) u_ms_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(mode_select_debug_pin),
        .level(ms_level)
    );

    ////////////////////////////////////////////////////////////////////////

    // one decode of the run state feeds both the status word and clock gate
    function automatic logic cpu_runs(input omc_state_t st);
        return st == ST_RUN;
    endfunction : cpu_runs

    // read mux; unmapped offsets read zero
    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input omc_regs_t r);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            OFS_STATUS: begin
                v[STAT_MODE_LSB +: 2] = r.st;
                v[STAT_STRAP_LOW] = r.strap_low;
                v[STAT_CPU_CLK] = cpu_runs(r.st);
            end
            OFS_PINFN: v[2:0] = r.pinfn;
            OFS_PULL_LO: v = r.pull[31:0];
            OFS_PULL_HI: v = r.pull[63:32];
            OFS_SLEW_LO: v = r.slew[31:0];
            OFS_SLEW_HI: v = r.slew[63:32];
            default: v = 32'h0;
        endcase
        return v;
    endfunction : rd_word

    // only the lowest 256 bytes of the slave window hold registers
    function automatic logic is_mapped(input logic [31:0] a);
        return a[31:8] == 24'h0;
    endfunction : is_mapped

    // pin functions take these pads away from the port registers
    function automatic logic [PAD_W-1:0] pad_force(
            input logic [PAD_W-1:0] v,
            input logic [2:0] fn,
            input logic dbg_val);
        logic [PAD_W-1:0] p;
        p = v;
        if (fn[PINFN_DBG_OWN]) begin
            p[PAD_DBG] = dbg_val;
        end
        if (fn[PINFN_XOUT]) begin
            p[PAD_XOUT] = 1'b0;
        end
        if (fn[PINFN_XIN]) begin
            p[PAD_XIN] = 1'b0;
        end
        return p;
    endfunction : pad_force

    ////////////////////////////////////////////////////////////////////////

    assign cmd = omc_cmd_t'(dbg_cmd_code);
    assign cmd_halt = dbg_cmd_valid && (cmd == CMD_HALT);
    assign cmd_nonintr = (cmd == CMD_MEM) || (cmd == CMD_MEM_STAT) ||
                         (cmd == CMD_BDC_REG) || (cmd == CMD_HALT);
    assign bus_take = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;
        next_s.vec_fetch = 1'b0;
        next_s.ccr_clr = 1'b0;
        next_s.stack_go = 1'b0;
        next_s.step = 1'b0;
        next_s.acc = 1'b0;
        next_s.rej = 1'b0;
        next_s.err = 1'b0;

        unique case (s.st)
            ST_INIT: begin
                // judge the pin once it has crossed the synchroniser
                if (s.init_cnt == INIT_CYCLES) begin
                    next_s.strap_low = ~ms_level;
                    if (ms_level) begin
                        next_s.st = ST_RUN;
                        next_s.vec_fetch = 1'b1;
                    end else begin
                        next_s.st = ST_ENTER_DEBUG_INSTRUCTION;
                    end
                end else begin
                    next_s.init_cnt = s.init_cnt + 2'h1;
                end
                // commands before the mode is known have nowhere to go
                if (dbg_cmd_valid) begin
                    next_s.rej = 1'b1;
                end
            end
            ST_RUN: begin
                if (dbg_cmd_valid) begin
                    next_s.acc = cmd_nonintr;
                    next_s.rej = ~cmd_nonintr;
                end
                // halt, then enter-debug, then breakpoints, then pause
                if (cmd_halt) begin
                    next_s.st = ST_ENTER_DEBUG_INSTRUCTION;
                end else if (enter_debug_instruction) begin
                    next_s.st = ST_ENTER_DEBUG_INSTRUCTION;
                end else if (bdc_breakpoint || dbg_breakpoint) begin
                    next_s.st = ST_ENTER_DEBUG_INSTRUCTION;
                end else if (low_power_pause_instruction) begin
                    next_s.st = ST_WAIT;
                    next_s.ccr_clr = 1'b1;
                end
            end
            ST_ENTER_DEBUG_INSTRUCTION: begin
                // cpu holds here until a resume command
                if (dbg_cmd_valid) begin
                    next_s.acc = 1'b1;
                    unique case (cmd)
                        CMD_GO: begin
                            next_s.st = ST_RUN;
                        end
                        CMD_TRACE: begin
                            next_s.step = 1'b1;
                        end
                        default: begin
                            next_s.step = 1'b0;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                if (dbg_cmd_valid) begin
                    unique case (cmd)
                        CMD_HALT: begin
                            next_s.acc = 1'b1;
                        end
                        CMD_MEM_STAT: begin
                            next_s.acc = 1'b1;
                            next_s.err = 1'b1;
                        end
                        default: begin
                            next_s.rej = 1'b1;
                        end
                    endcase
                end
                // halt beats a simultaneous interrupt
                if (cmd_halt) begin
                    next_s.st = ST_ENTER_DEBUG_INSTRUCTION;
                end else if (irq_request) begin
                    next_s.st = ST_RUN;
                    next_s.stack_go = 1'b1;
                end
            end
        endcase

        // write data phase of the previous access
        if (s.wr_pend) begin
            case (s.wr_addr)
                OFS_PINFN: next_s.pinfn = hwdata[2:0];
                OFS_PULL_LO: next_s.pull[31:0] = hwdata;
                OFS_PULL_HI: next_s.pull[63:32] = hwdata;
                OFS_SLEW_LO: next_s.slew[31:0] = hwdata;
                OFS_SLEW_HI: next_s.slew[63:32] = hwdata;
                default: next_s.wr_addr = s.wr_addr;
            endcase
        end
        next_s.wr_pend = 1'b0;

        // address phase; reads see any write landing this cycle
        if (bus_take) begin
            if (hwrite) begin
                next_s.wr_pend = is_mapped(haddr) && (hsize == 3'h2);
                next_s.wr_addr = haddr[7:0];
            end else if (is_mapped(haddr)) begin
                next_s.rdata = rd_word(haddr[7:0], next_s);
            end else begin
                next_s.rdata = 32'h0;
            end
        end

        // pad controls with function overrides
        next_s.pad_pu = pad_force(next_s.pull, next_s.pinfn, 1'b1);
        next_s.pad_sr = pad_force(next_s.slew, next_s.pinfn, 1'b0);
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= REGS_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // zero wait states: every access completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;

    assign dbg_cmd_done = s.acc;
    assign dbg_cmd_rejected = s.rej;
    assign dbg_status_paused = s.err;

    // cpu clock gated in background and pause, system clock untouched
    assign cpu_clk_en = cpu_runs(s.st);
    assign vector_fetch = s.vec_fetch;
    assign vector_addr = RESET_VECTOR_ADDR;
    assign ccr_imask_clear = s.ccr_clr;
    assign stacking_start = s.stack_go;
    assign trace_step = s.step;
    assign op_mode = s.st;

    assign pad_pullup_en = s.pad_pu;
    assign pad_slew_en = s.pad_sr;

endmodule : omc_mode_ctrl

// *** src/omc_sync.sv ***
/*
 * Two-flop level synchroniser for one asynchronous pin.
 * Assumes the pin may change at any time relative to hclk.
 */
module omc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic meta;
        logic level;
    } omc_sync_regs_t;

    omc_sync_regs_t s;
    omc_sync_regs_t next_s;

    // meta feeds only the second flop
    always_comb begin
        next_s.meta = pin;
        next_s.level = s.meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{meta: RESET_VAL, level: RESET_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;

endmodule : omc_sync

// *** verification/omc_host_model.sv ***
/* debug host model: mode strap and decoded commands
   assumes the bench calls strap before each reset release */
module omc_host_model import omc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    output logic mode_select_debug_pin,
    output logic dbg_cmd_valid,
    output logic [2:0] dbg_cmd_code
);
timeunit 1ns;
timeprecision 1ns;
initial begin
    mode_select_debug_pin = 1'b1;
    dbg_cmd_valid = 1'b0;
    dbg_cmd_code = 3'h0;
end
task strap(input logic low);
    @(posedge hclk);
    mode_select_debug_pin <= !low;
    @(posedge hresetn);
    repeat (4) @(posedge hclk);
    mode_select_debug_pin <= 1'b1; // released: pull-up wins
endtask : strap
task send(input logic [2:0] c);
    @(posedge hclk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd_code <= c;
    @(posedge hclk);
    dbg_cmd_valid <= 1'b0;
    dbg_cmd_code <= ~c; // idle code is garbage, never a copy
endtask : send
endmodule : omc_host_model

// *** verification/omc_mode_ctrl_bench.sv ***
/* self-checking bench for omc_mode_ctrl
   assumes one slave on the bus, so hready follows hreadyout */
module omc_mode_ctrl_bench import omc_pkg::*;;
timeunit 1ns;
timeprecision 1ns;
logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata, q;
logic [1:0] htrans, op_mode;
logic [2:0] hsize, dbg_cmd_code;
logic mode_select_debug_pin, dbg_cmd_valid, dbg_cmd_done;
logic dbg_cmd_rejected, dbg_status_paused, trace_step;
logic cpu_clk_en, vector_fetch, ccr_imask_clear, stacking_start;
logic [15:0] vector_addr;
logic [4:0] ev;
logic enter_debug_instruction, low_power_pause_instruction;
logic bdc_breakpoint, dbg_breakpoint, irq_request;
logic [PAD_W-1:0] pad_pullup_en, pad_slew_en, pu, sl;
logic [2:0] rej [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6};
int failures, n_compared;
assign hready = hreadyout;
assign {irq_request, low_power_pause_instruction, dbg_breakpoint,
        bdc_breakpoint, enter_debug_instruction} = ev;
omc_mode_ctrl dut (.*);
omc_host_model host (.*);
initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
end
////////////////////////////////////////////////////////////////////////////
function automatic logic [PAD_W-1:0] exp_pad(input logic [PAD_W-1:0] v,
        input logic [2:0] f, input logic dbg);
    exp_pad = v;
    if (f[PINFN_DBG_OWN]) exp_pad[PAD_DBG] = dbg;
    if (f[PINFN_XOUT]) exp_pad[PAD_XOUT] = 1'b0;
    if (f[PINFN_XIN]) exp_pad[PAD_XIN] = 1'b0;
endfunction : exp_pad
task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
        failures++;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask : check
task give_verdict;
    if (failures == 0 && n_compared > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask : give_verdict
task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    check("hresp", hresp, 1'b0);
    #1;
endtask : bus
task do_reset(input logic low);
    @(posedge hclk);
    fork host.strap(low); join_none
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    #1;
endtask : do_reset
task cmd(input logic [2:0] c, input logic [3:0] exp);
    host.send(c);
    #1;
    check("cmd answer", {dbg_cmd_done, dbg_cmd_rejected, dbg_status_paused,
          trace_step}, exp);
endtask : cmd
task pulse(input logic [4:0] e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= 5'h00;
    #1;
endtask : pulse
////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    give_verdict;
end
initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev = 5'h00;
    void'($urandom(71));
    do_reset(1'b1);
    check("boot low", op_mode, 2'h2);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("status low", q[3:0], 4'h6);
    cmd(CMD_GO, 4'h8);
    do_reset(1'b0);
    check("boot high", op_mode, 2'h1);
    check("vector", vector_addr, RESET_VECTOR_ADDR);
    check("pull reset", pad_pullup_en, exp_pad(PULL_RESET, PINFN_RESET, 1));
    for (int c = 0; c < 7; c++) if (c != 3) cmd(c, c < 4 ? 4'h8 : 4'h4);
    check("still run", op_mode, 2'h1);
    cmd(CMD_HALT, 4'h8);
    check("halt", op_mode, 2'h2);
    for (int c = 0; c < 6; c++) cmd(c, c == 5 ? 4'h9 : 4'h8);
    check("suspended", {op_mode, cpu_clk_en}, 3'h4);
    cmd(CMD_GO, 4'h8);
    check("go", op_mode, 2'h1);
    for (int i = 0; i < 3; i++) begin
        pulse(5'h01 << i);
        check("debug entry", op_mode, 2'h2);
        cmd(CMD_GO, 4'h8);
    end
    pulse(5'h08);
    check("pause", {op_mode, cpu_clk_en, ccr_imask_clear}, 4'hD);
    repeat (4) cmd(rej[$urandom_range(4)], 4'h4);
    cmd(CMD_MEM_STAT, 4'hA);
    pulse(5'h10);
    check("irq wake", {op_mode, stacking_start}, 3'h3);
    pulse(5'h08);
    cmd(CMD_HALT, 4'h8);
    check("pause halt", op_mode, 2'h2);
    cmd(CMD_GO, 4'h8);
    for (int f = 0; f < 8; f++) begin
        pu = {$urandom, $urandom};
        sl = {$urandom, $urandom};
        bus(1'b1, OFS_PINFN, f);
        bus(1'b1, OFS_PULL_LO, pu[31:0]);
        bus(1'b1, OFS_PULL_HI, pu[63:32]);
        bus(1'b1, OFS_SLEW_LO, sl[31:0]);
        bus(1'b1, OFS_SLEW_HI, sl[63:32]);
        check("pullup", pad_pullup_en, exp_pad(pu, f, 1));
        check("slew", pad_slew_en, exp_pad(sl, f, 0));
        bus(1'b0, OFS_PULL_HI, 32'h0);
        check("pull read", q, pu[63:32]);
    end
    bus(1'b0, 32'h100, 32'h0);
    check("unmapped", q, 32'h0);
    give_verdict;
end
endmodule : omc_mode_ctrl_bench

// *** verification/omc_mode_ctrl_props.sv ***
/* assertions on the mode control ports
   assumes one clock, bound into every omc_mode_ctrl */
module omc_mode_ctrl_props import omc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dbg_cmd_valid,
    input wire logic [2:0] dbg_cmd_code,
    input wire logic dbg_cmd_done,
    input wire logic dbg_cmd_rejected,
    input wire logic dbg_status_paused,
    input wire logic enter_debug_instruction,
    input wire logic low_power_pause_instruction,
    input wire logic bdc_breakpoint,
    input wire logic dbg_breakpoint,
    input wire logic irq_request,
    input wire logic cpu_clk_en,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr,
    input wire logic ccr_imask_clear,
    input wire logic stacking_start,
    input wire logic [1:0] op_mode
);
timeunit 1ns;
timeprecision 1ns;
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
logic halt;
logic go;
logic bp;
assign halt = dbg_cmd_valid && dbg_cmd_code == CMD_HALT;
assign go = dbg_cmd_valid && dbg_cmd_code == CMD_GO;
assign bp = enter_debug_instruction || bdc_breakpoint || dbg_breakpoint;
////////////////////////////////////////////////////////////////////////////
property p_boot;
    op_mode == 2'h1 && $past(op_mode) == 2'h0
        |-> vector_fetch && vector_addr == RESET_VECTOR_ADDR;
endproperty
a_boot: assert property (p_boot) else $error("no vector fetch");
property p_halt;
    halt && op_mode inside {2'h1, 2'h3} |=> op_mode == 2'h2 && dbg_cmd_done;
endproperty
a_halt: assert property (p_halt) else $error("halt missed");
property p_rej;
    dbg_cmd_valid && dbg_cmd_code >= 3'h4 && op_mode == 2'h1
        |=> dbg_cmd_rejected && !dbg_cmd_done;
endproperty
a_rej: assert property (p_rej) else $error("run accepted cpu cmd");
property p_go;
    go && op_mode == 2'h2 |=> op_mode == 2'h1 && cpu_clk_en;
endproperty
a_go: assert property (p_go) else $error("resume missed");
property p_susp;
    op_mode == 2'h2 && !go |=> op_mode == 2'h2 && !cpu_clk_en;
endproperty
a_susp: assert property (p_susp) else $error("left suspend");
property p_entry;
    op_mode == 2'h1 && bp |=> op_mode == 2'h2;
endproperty
a_entry: assert property (p_entry) else $error("no debug entry");
property p_pause;
    op_mode == 2'h1 && low_power_pause_instruction && !halt && !bp
        |=> op_mode == 2'h3 && ccr_imask_clear && !cpu_clk_en;
endproperty
a_pause: assert property (p_pause) else $error("pause bad");
property p_wake;
    op_mode == 2'h3 && irq_request && !halt |=> op_mode == 2'h1 && stacking_start;
endproperty
a_wake: assert property (p_wake) else $error("wake bad");
property p_stat;
    dbg_cmd_valid && dbg_cmd_code == CMD_MEM_STAT && op_mode == 2'h3
        |=> dbg_cmd_done && dbg_status_paused;
endproperty
a_stat: assert property (p_stat) else $error("paused status bad");
property p_prej;
    dbg_cmd_valid && op_mode == 2'h3 && !halt && dbg_cmd_code != CMD_MEM_STAT
        |=> dbg_cmd_rejected;
endproperty
a_prej: assert property (p_prej) else $error("pause accepted cmd");
c_wake: cover property (op_mode == 2'h3 && irq_request);
c_phalt: cover property (halt && op_mode == 2'h3);
c_trace: cover property (dbg_cmd_valid && dbg_cmd_code == CMD_TRACE);
endmodule : omc_mode_ctrl_props
bind omc_mode_ctrl omc_mode_ctrl_props u_props (.*);
